// [hw/spi4tx_pkg.sv]
// Shared constants, types and helpers of the transmit write port
package spi4tx_pkg;
    localparam int DATA_W     = 128;            // One wide line
    localparam int BE_W       = 16;             // One enable per byte
    localparam int NUM_PART   = 8;              // Partitions per RAM
    localparam int PADDR_W    = 3;              // Partition address
    localparam int DEPTH_32   = 4;              // Lines, narrow mode
    localparam int PART_DEPTH = 4 * DEPTH_32;   // Wide mode is 4x deeper
    localparam int LINE_AW    = $clog2(PART_DEPTH);
    localparam int PTR_W      = LINE_AW + 1;    // Extra wrap bit
    localparam int MEM_AW     = PADDR_W + LINE_AW;
    localparam int PORT_W     = 8;
    localparam int STAT_W     = 2;
    localparam int BURST_W    = 4;
    localparam int FLAG_W     = 3;              // Start, end, error
    localparam int SOP_BIT    = 2;
    localparam int EOP_BIT    = 1;
    localparam int ERR_BIT    = 0;

    // Values after reset, step sizes and limits
    localparam logic [PTR_W-1:0]   PTR_RST   = 5'h00;
    localparam logic [PTR_W-1:0]   PTR_ONE   = 5'h01;
    localparam logic [PTR_W-1:0]   FILL_MAX  = 5'h10;
    localparam logic [PORT_W-1:0]  PORT_RST  = 8'h00;
    localparam logic [STAT_W-1:0]  STAT_RST  = 2'h0;
    localparam logic [BURST_W-1:0] BURST_RST = 4'h0;
    localparam logic [BURST_W-1:0] BURST_ONE = 4'h1;
    localparam logic [BE_W-1:0]    BE_NONE   = 16'h0000;

    // Service sequencer states
    typedef enum logic [0:0]
    {
        SVC_IDLE = 1'b0,
        SVC_READ = 1'b1
    } svc_state_t;

    // Gray to binary for crossed pointers
    function automatic logic [PTR_W-1:0] gray2bin
    (
        input logic [PTR_W-1:0] g
    );
        logic [PTR_W-1:0] b;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--)
            b[i] = b[i+1] ^ g[i];
        return b;
    endfunction : gray2bin

    // Binary to gray before a pointer leaves its domain
    function automatic logic [PTR_W-1:0] bin2gray
    (
        input logic [PTR_W-1:0] b
    );
        return b ^ (b >> 1);
    endfunction : bin2gray
endpackage : spi4tx_pkg

// [hw/gray_ptr_if.sv]
// Carrier for one gray pointer crossing between clock domains
`timescale 1ns/1ps
`default_nettype none
interface gray_ptr_if #(parameter int W = 5) ();
    logic [W-1:0] gray_src;   // Pointer in its home domain
    logic [W-1:0] gray_dst;   // Same pointer, resynchronised
    modport src  (output gray_src, input gray_dst);
    modport sync (input gray_src, output gray_dst);
endinterface : gray_ptr_if
`default_nettype wire

// [hw/ptr_sync.sv]
// Two-stage synchroniser for one gray-coded pointer
`timescale 1ns/1ps
`default_nettype none
module ptr_sync #(
    parameter int W = 5                     // Pointer width
) (
    input  wire logic dst_clk,              // Receiving clock
    input  wire logic dst_rst,              // Receiving reset, sync
    gray_ptr_if.sync  xp                    // Pointer to carry across
);
    logic [W-1:0] meta_ff;                  // First stage, nothing else reads
    logic [W-1:0] gray_ff;                  // Second stage, safe to use

    // Only one bit moves per step, so a torn sample is still a real value
    always_ff @(posedge dst_clk)
    begin
        if (dst_rst)
        begin
            meta_ff <= '0;
            gray_ff <= '0;
        end
        else
        begin
            meta_ff <= xp.gray_src;
            gray_ff <= meta_ff;
        end
    end

    assign xp.gray_dst = gray_ff;
endmodule : ptr_sync
`default_nettype wire

// [hw/spi4_tx_user_write_port.sv]
// Wide transmit write port: partitioned line buffer and service outputs
// Behaviour
// R01: Write clock independent of every other clock
// R02: Full flag follows the presented partition address
// R03: Full flag high once fill crosses threshold
// R04: Port number is link value or substitute
// R05: Show two-bit status of serviced port
// R06: Show four-bit burst length of serviced port
// R07: One line read attempt per burst cycle
// R08: User supplies quarter-rate reference clock; this port has no reference clock input
// R09: Strap low: centre status clock internally
// R10: Strap high: no internal centring applied
// R11: Three-bit address selects one of eight partitions
// R12: Wide partition four times narrow depth
// R13: Several ports may share one partition
// R14: One write fills a whole wide line
// R15: All enables low: data dropped, no write
// R16: User enables all bytes except last
// R17: Start flag with first line of packet
// R18: Error flag only with end flag
// R19: End of packet advances write pointer
// R20: Capture only when write enable high
`timescale 1ns/1ps
`default_nettype none
module spi4_tx_user_write_port
    import spi4tx_pkg::*;
(
    input  wire logic                    core_clk,        // Core clock
    input  wire logic                    srst,            // Sync reset
    input  wire logic                    tx_user_write_clock, // Write clk
    input  wire logic                    wide_write_en,   // Write strobe
    input  wire logic [PADDR_W-1:0]      partition_write_addr_wide, // Part
    input  wire logic [DATA_W-1:0]       wide_write_data, // Line data
    input  wire logic [BE_W-1:0]         wide_byte_enables, // Byte valid
    input  wire logic                    wide_packet_start_flag, // Start
    input  wire logic                    wide_packet_end_flag, // End
    input  wire logic                    wide_packet_error_flag, // Error
    input  wire logic [PTR_W-1:0]        fill_threshold,  // Full level
    output logic                         partition_full_flag, // Fill flag
    input  wire logic                    svc_start,       // New service
    input  wire logic [PORT_W-1:0]       svc_port,        // Link port
    input  wire logic [STAT_W-1:0]       svc_status,      // Port status
    input  wire logic [BURST_W-1:0]      svc_burst,       // Cycles
    input  wire logic [PADDR_W-1:0]      svc_partition,   // Port's part
    input  wire logic                    port_sub_en,     // Use substitute
    input  wire logic [PORT_W-1:0]       port_sub_value,  // Substitute
    output logic [PORT_W-1:0]            serviced_port_number, // Port
    output logic [STAT_W-1:0]            serviced_port_status, // Status
    output logic [BURST_W-1:0]           service_burst_length, // Burst
    output logic                         service_busy,    // Burst running
    output logic                         line_out_valid,  // Line read
    output logic [DATA_W-1:0]            line_out_data,   // Line data
    output logic [BE_W-1:0]              line_out_be,     // Line enables
    output logic [FLAG_W-1:0]            line_out_flags,  // Start/end/err
    output logic                         line_out_miss,   // Empty attempt
    input  wire logic                    status_clock_align_select, // Strap
    output logic                         status_clock_centre_en // Centring
);
    // Line storage, written on the user clock, read on the core clock
    logic [DATA_W-1:0]  line_mem  [NUM_PART*PART_DEPTH]; // R12
    logic [BE_W-1:0]    be_mem    [NUM_PART*PART_DEPTH];
    logic [FLAG_W-1:0]  flag_mem  [NUM_PART*PART_DEPTH];

    logic [PTR_W-1:0]   wr_bin_ff  [NUM_PART];  // Write pointers
    logic [PTR_W-1:0]   wr_gray_ff [NUM_PART];  // Same, gray coded
    logic [PTR_W-1:0]   rd_bin_ff  [NUM_PART];  // Read pointers
    logic [PTR_W-1:0]   rd_gray_ff [NUM_PART];  // Same, gray coded
    logic [PTR_W-1:0]   rd_seen    [NUM_PART];  // Read ptr, write side
    logic [PTR_W-1:0]   wr_seen    [NUM_PART];  // Write ptr, core side

    logic               rst_meta_ff;            // Reset sync stage 1
    logic               wr_rst_ff;              // Reset, write domain
    logic [PTR_W-1:0]   wr_fill;                // Fill of addressed part
    logic               wr_accept;              // Line goes to memory

    svc_state_t         svc_state_ff;           // Service sequencer
    logic [BURST_W-1:0] burst_left_ff;          // Attempts remaining
    logic [PADDR_W-1:0] svc_part_ff;            // Partition serviced
    logic               svc_take;               // Service accepted
    logic               rd_hit;                 // Attempt finds a line
    logic               strap_meta_ff;          // Strap sync stage 1
    logic               strap_sync_ff;          // Strap sync stage 2
    logic               strap_caught_ff;        // Strap taken once

    // Pointer crossings, one pair per partition
    for (genvar p = 0; p < NUM_PART; p++)
    begin : g_part
        gray_ptr_if #(.W(PTR_W)) wx ();
        gray_ptr_if #(.W(PTR_W)) rx ();
        assign wx.gray_src = wr_gray_ff[p];
        assign rx.gray_src = rd_gray_ff[p];
        assign wr_seen[p]  = gray2bin(wx.gray_dst);
        assign rd_seen[p]  = gray2bin(rx.gray_dst);
        // The write clock shares no phase with the core clock
        ptr_sync #(.W(PTR_W)) u_wr_sync                             // R01
        (
            .dst_clk (core_clk),
            .dst_rst (srst),
            .xp      (wx.sync)
        );
        ptr_sync #(.W(PTR_W)) u_rd_sync
        (
            .dst_clk (tx_user_write_clock),
            .dst_rst (wr_rst_ff),
            .xp      (rx.sync)
        );
    end

    // Reset carried into the write domain; it may lag by a few edges
    always_ff @(posedge tx_user_write_clock)
    begin
        rst_meta_ff <= srst;
        wr_rst_ff   <= rst_meta_ff;
    end

    // Fill of the addressed partition, seen from the write side
    assign wr_fill = wr_bin_ff[partition_write_addr_wide]           // R11
                   - rd_seen[partition_write_addr_wide];

    // A line is stored only with a strobe, some enable, and room
    assign wr_accept = wide_write_en                                // R20
                     && (wide_byte_enables != BE_NONE)              // R15
                     && (wr_fill != FILL_MAX);

    // Memory write: the whole line in one go, no read-modify-write
    always_ff @(posedge tx_user_write_clock)
    begin
        if (wr_accept)
        begin
            line_mem[{partition_write_addr_wide,                    // R14
                wr_bin_ff[partition_write_addr_wide][LINE_AW-1:0]}]
                <= wide_write_data;
            be_mem[{partition_write_addr_wide,
                wr_bin_ff[partition_write_addr_wide][LINE_AW-1:0]}]
                <= wide_byte_enables;
            // Flags kept as given; the user pairs error with end
            flag_mem[{partition_write_addr_wide,                    // R17
                wr_bin_ff[partition_write_addr_wide][LINE_AW-1:0]}]
                <= {wide_packet_start_flag, wide_packet_end_flag,   // R18
                    wide_packet_error_flag};
        end
    end

    // Write pointers: each stored line, end of packet included, moves on
    always_ff @(posedge tx_user_write_clock)
    begin
        if (wr_rst_ff)
        begin
            for (int i = 0; i < NUM_PART; i++)
            begin
                wr_bin_ff[i]  <= PTR_RST;
                wr_gray_ff[i] <= PTR_RST;
            end
        end
        else if (wr_accept)
        begin
            // Pointer wraps inside the partition's own range
            wr_bin_ff[partition_write_addr_wide] <=                 // R19
                wr_bin_ff[partition_write_addr_wide] + PTR_ONE;
            wr_gray_ff[partition_write_addr_wide] <= bin2gray(
                wr_bin_ff[partition_write_addr_wide] + PTR_ONE);
        end
    end

    // Full flag tracks whichever partition is addressed now
    always_ff @(posedge tx_user_write_clock)
    begin
        if (wr_rst_ff)
            partition_full_flag <= 1'b0;
        else
            partition_full_flag <= (wr_fill >= fill_threshold);     // R02 R03
    end

    // A new service is taken only when the last burst is done
    assign svc_take = svc_start && (svc_state_ff == SVC_IDLE)
                    && (svc_burst != BURST_RST);
    assign rd_hit   = (svc_state_ff == SVC_READ)
                    && (rd_bin_ff[svc_part_ff] != wr_seen[svc_part_ff]);

    // Service identity outputs, latched at the start of each burst
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            serviced_port_number <= PORT_RST;
            serviced_port_status <= STAT_RST;
            service_burst_length <= BURST_RST;
            svc_part_ff          <= '0;
        end
        else if (svc_take)
        begin
            // Substitute number hides the link port from user logic
            serviced_port_number <= port_sub_en ? port_sub_value    // R04
                                                : svc_port;
            serviced_port_status <= svc_status;                     // R05
            service_burst_length <= svc_burst;                      // R06
            // The port-to-partition choice comes with the service
            svc_part_ff          <= svc_partition;                  // R13
        end
    end

    // Burst sequencer: one attempt per cycle for the burst length
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            svc_state_ff  <= SVC_IDLE;
            burst_left_ff <= BURST_RST;
            service_busy  <= 1'b0;
        end
        else
        begin
            unique case (svc_state_ff)
                SVC_IDLE:
                begin
                    // Zero-length services are ignored outright
                    if (svc_take)
                    begin
                        svc_state_ff  <= SVC_READ;
                        burst_left_ff <= svc_burst;
                        service_busy  <= 1'b1;
                    end
                end
                SVC_READ:
                begin
                    burst_left_ff <= burst_left_ff - BURST_ONE;     // R07
                    if (burst_left_ff == BURST_ONE)
                    begin
                        svc_state_ff <= SVC_IDLE;
                        service_busy <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Read pointers advance only on attempts that found a line
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < NUM_PART; i++)
            begin
                rd_bin_ff[i]  <= PTR_RST;
                rd_gray_ff[i] <= PTR_RST;
            end
        end
        else if (rd_hit)
        begin
            rd_bin_ff[svc_part_ff]  <= rd_bin_ff[svc_part_ff] + PTR_ONE;
            rd_gray_ff[svc_part_ff] <= bin2gray(
                rd_bin_ff[svc_part_ff] + PTR_ONE);
        end
    end

    // Line output; a miss is an attempt that met an empty partition
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            line_out_valid <= 1'b0;
            line_out_miss  <= 1'b0;
            line_out_data  <= '0;
            line_out_be    <= BE_NONE;
            line_out_flags <= '0;
        end
        else
        begin
            line_out_valid <= rd_hit;                               // R07
            line_out_miss  <= (svc_state_ff == SVC_READ) && !rd_hit;
            if (rd_hit)
            begin
                line_out_data  <= line_mem[{svc_part_ff,
                    rd_bin_ff[svc_part_ff][LINE_AW-1:0]}];
                line_out_be    <= be_mem[{svc_part_ff,
                    rd_bin_ff[svc_part_ff][LINE_AW-1:0]}];
                line_out_flags <= flag_mem[{svc_part_ff,
                    rd_bin_ff[svc_part_ff][LINE_AW-1:0]}];
            end
        end
    end

    // Strap synchroniser; a pin is never read before two stages
    always_ff @(posedge core_clk)
    begin
        strap_meta_ff <= status_clock_align_select;
        strap_sync_ff <= strap_meta_ff;
    end

    // Strap caught once after reset; later changes are ignored
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            strap_caught_ff        <= 1'b0;
            status_clock_centre_en <= 1'b1;
        end
        else if (!strap_caught_ff)
        begin
            strap_caught_ff        <= 1'b1;
            status_clock_centre_en <= !strap_sync_ff;               // R09 R10
        end
    end

    // Helper: count of stored lines, for the checks below only
    logic [7:0] wr_total_ff;
    always_ff @(posedge tx_user_write_clock)
    begin
        if (wr_rst_ff)
            wr_total_ff <= 8'h00;
        else if (wr_accept)
            wr_total_ff <= wr_total_ff + 8'h01;
    end

    // Core reset mutes the write-side checks too: the carried reset is
    // unknown until its two stages have filled
    a_zero_be_drop: assert property (                               // R15
        @(posedge tx_user_write_clock) disable iff (srst || wr_rst_ff)
        (wide_write_en && wide_byte_enables == BE_NONE)
        |=> $stable(wr_total_ff))
        else $error("line stored with no byte enabled");
    a_strobe_capture: assert property (                             // R20
        @(posedge tx_user_write_clock) disable iff (srst || wr_rst_ff)
        !wide_write_en |=> $stable(wr_total_ff))
        else $error("line stored without write enable");
    a_single_line_write: assert property (                          // R14
        @(posedge tx_user_write_clock) disable iff (srst || wr_rst_ff)
        wr_accept |=> wr_total_ff == $past(wr_total_ff) + 8'h01)
        else $error("accepted write did not store one line");
    a_eop_ptr_advance: assert property (                            // R19
        @(posedge tx_user_write_clock) disable iff (srst || wr_rst_ff)
        (wr_accept && wide_packet_end_flag)
        |=> wr_bin_ff[$past(partition_write_addr_wide)]
            != $past(wr_bin_ff[partition_write_addr_wide]))
        else $error("end of packet left pointer in place");
    a_full_flag_level: assert property (                            // R03
        @(posedge tx_user_write_clock) disable iff (srst || wr_rst_ff)
        $past(!wr_rst_ff) && (wr_fill >= fill_threshold)
        |=> partition_full_flag)
        else $error("full flag low above threshold");
    a_port_id_pick: assert property (                               // R04
        @(posedge core_clk) disable iff (srst)
        svc_take |=> serviced_port_number
            == ($past(port_sub_en) ? $past(port_sub_value)
                                   : $past(svc_port)))
        else $error("serviced port number wrong");
    a_status_burst_show: assert property (                          // R06
        @(posedge core_clk) disable iff (srst)
        svc_take |=> service_burst_length == $past(svc_burst)
            && serviced_port_status == $past(svc_status))
        else $error("status or burst not shown");
    a_burst_three_reads: assert property (                          // R07
        @(posedge core_clk) disable iff (srst)
        (svc_take && svc_burst == 4'h3)
        |=> service_busy [*3] ##1 !service_busy)
        else $error("burst of three not three attempts");
    a_read_in_burst: assert property (                              // R07
        @(posedge core_clk) disable iff (srst)
        (line_out_valid || line_out_miss) |-> $past(service_busy))
        else $error("read attempt outside a burst");
    a_strap_centre: assert property (                               // R09
        @(posedge core_clk) disable iff (srst)
        $rose(strap_caught_ff)
        |-> status_clock_centre_en == !$past(strap_sync_ff))
        else $error("status clock centring does not match strap");

    c_eop_stored: cover property (
        @(posedge tx_user_write_clock) disable iff (srst || wr_rst_ff)
        wr_accept && wide_packet_end_flag);
    c_full_rise: cover property (
        @(posedge tx_user_write_clock) disable iff (srst || wr_rst_ff)
        $rose(partition_full_flag));
    c_line_read: cover property (
        @(posedge core_clk) disable iff (srst) line_out_valid);
    c_empty_miss: cover property (
        @(posedge core_clk) disable iff (srst) line_out_miss);
endmodule : spi4_tx_user_write_port
`default_nettype wire

// [dv/user_writer.sv]
// Model of the user logic that writes wide lines into the partitions
`timescale 1ns/1ps
`default_nettype none
module user_writer
    import spi4tx_pkg::*;
(
    input  wire logic          wclk,  // User write clock
    output logic               we,    // Write strobe
    output logic [PADDR_W-1:0] addr,  // Partition index
    output logic [DATA_W-1:0]  data,  // Line data
    output logic [BE_W-1:0]    be,    // Byte enables
    output logic [FLAG_W-1:0]  flags  // Start, end, error
);
    // Quiet bus at time zero
    initial
    begin
        we = 1'b0;
        addr = '0;
        data = '0;
        be = BE_NONE;
        flags = '0;
    end

    // One line per edge; back to back when called again at once
    task automatic put(input logic [PADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [BE_W-1:0] b, input logic [FLAG_W-1:0] f);
        @(posedge wclk);
        #1;
        we = 1'b1;
        addr = a;
        data = d;
        be = b;
        flags = f;
    endtask : put

    // Release: stale data is inverted so nothing looks like a valid line
    task automatic idle(input logic [PADDR_W-1:0] a);
        @(posedge wclk);
        #1;
        we = 1'b0;
        addr = a;
        data = ~data;
        flags = ~flags;
    endtask : idle
endmodule : user_writer
`default_nettype wire

// [dv/test_spi4_tx_user_write_port.sv]
// Self-checking bench for the wide transmit write port
`timescale 1ns/1ps
`default_nettype none
module test_spi4_tx_user_write_port;
    import spi4tx_pkg::*;
    logic core_clk = 0, wclk = 0, srst = 1, strap = 0, full, busy;
    logic we, lv, lm, svc_start = 0, sub_en = 0, centre;
    logic [PADDR_W-1:0] wa, svc_part = '0;
    logic [DATA_W-1:0]  wd, ld;
    logic [BE_W-1:0]    wb, lb;
    logic [FLAG_W-1:0]  wf, lf;
    logic [PORT_W-1:0]  svc_port = '0, sub_val = '0, pnum;
    logic [STAT_W-1:0]  svc_stat = '0, pstat;
    logic [BURST_W-1:0] svc_burst = '0, pburst;
    logic [147:0]       q[$], got; // Expected lines, oldest first
    logic [31:0]        seed = 32'h71BF;
    int bad_count = 0, samples_checked = 0, n;

    always #2.5 core_clk = ~core_clk;
    // Write clock free running, offset so no edge meets a core edge;
    // it runs at one third of the core clock rate
    initial
    begin
        #1.2;
        forever #7.5 wclk = ~wclk;
    end

    user_writer i_user_writer (.wclk(wclk), .we(we), .addr(wa), .data(wd),
        .be(wb), .flags(wf));

    spi4_tx_user_write_port i_spi4_tx_user_write_port (
        .core_clk(core_clk), .srst(srst), .tx_user_write_clock(wclk),
        .wide_write_en(we), .partition_write_addr_wide(wa),
        .wide_write_data(wd), .wide_byte_enables(wb),
        .wide_packet_start_flag(wf[SOP_BIT]),
        .wide_packet_end_flag(wf[EOP_BIT]),
        .wide_packet_error_flag(wf[ERR_BIT]), .fill_threshold(5'h0C),
        .partition_full_flag(full), .svc_start(svc_start),
        .svc_port(svc_port), .svc_status(svc_stat), .svc_burst(svc_burst),
        .svc_partition(svc_part), .port_sub_en(sub_en),
        .port_sub_value(sub_val), .serviced_port_number(pnum),
        .serviced_port_status(pstat), .service_burst_length(pburst),
        .service_busy(busy), .line_out_valid(lv), .line_out_data(ld),
        .line_out_be(lb), .line_out_flags(lf), .line_out_miss(lm),
        .status_clock_align_select(strap),
        .status_clock_centre_en(centre));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string nm, input logic [147:0] e,
                       input logic [147:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Write a random line; note it unless every enable is low
    task automatic send(input logic [PADDR_W-1:0] a, input logic [BE_W-1:0] b,
                        input logic [FLAG_W-1:0] f);
        logic [DATA_W-1:0] d;
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            d = {d[95:0], seed};
        end
        i_user_writer.put(a, d, b, f);
        if (b !== BE_NONE)
            q.push_back({1'b0, f, b, d});
    endtask : send

    // One service; the partition is assumed to hold lines lines
    task automatic serve(input logic [PADDR_W-1:0] p, input int burst,
                         input logic sub, input int lines);
        #1;
        seed = lfsr(seed);
        {svc_port, sub_val, svc_stat} = seed[17:0];
        {svc_part, svc_burst, sub_en} = {p, burst[3:0], sub};
        svc_start = 1'b1;
        @(posedge core_clk);
        #1;
        svc_start = 1'b0;
        for (int i = lines; i < burst; i++)
            q.push_back({1'b1, 147'h0});
        chk("port", sub ? sub_val : svc_port, pnum);
        chk("status", svc_stat, pstat);
        chk("burst", burst, pburst);
        // Busy is looked at just after each edge, where it has settled
        for (n = 0; busy === 1'b1 && n < 40; n++)
        begin
            @(posedge core_clk);
            #1;
        end
        chk("busy_cycles", burst, n);
        repeat (3) @(posedge core_clk);
    endtask : serve

    // Each read attempt is paired with the oldest expectation
    always @(posedge core_clk)
        if (lv === 1'b1 || lm === 1'b1)
        begin
            got = lm ? {1'b1, 147'h0} : {1'b0, lf, lb, ld};
            chk("line", q.size() ? q.pop_front() : 'x, got);
        end

    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        #100000;
        bad_count++;
        wrap_up();
    end

    initial
    begin
        // Reset twice to see both strap settings
        for (int s = 1; s >= 0; s--)
        begin
            strap = s[0];
            srst = 1'b1;
            repeat (14) @(posedge core_clk);
            #1;
            srst = 1'b0;
            @(posedge core_clk);
            #1;
            chk("centre_en", !s[0], centre);
        end
        repeat (5) @(posedge wclk);
        send(3'h2, 16'hFFFF, 3'h4);
        send(3'h2, 16'h0000, 3'h0);
        send(3'h2, 16'hFFFF, 3'h0);
        send(3'h2, 16'hFFC0, 3'h3);
        i_user_writer.idle(3'h2);
        repeat (12) @(posedge core_clk);
        serve(3'h2, 4, 1'b0, 3);
        for (int i = 0; i < 12; i++)
        begin
            send(3'h5, 16'hFFFF, 3'h0);
            if (i == 10)
            begin
                i_user_writer.idle(3'h5);
                repeat (3) @(posedge wclk);
                chk("full_low", 1'b0, full);
            end
        end
        i_user_writer.idle(3'h5);
        repeat (3) @(posedge wclk);
        chk("full_high", 1'b1, full);
        i_user_writer.idle(3'h0);
        repeat (3) @(posedge wclk);
        chk("full_other", 1'b0, full);
        repeat (6) @(posedge core_clk);
        serve(3'h5, 8, 1'b1, 8);
        serve(3'h5, 15, 1'b0, 4);
        chk("left", 0, q.size());
        wrap_up();
    end
endmodule : test_spi4_tx_user_write_port
`default_nettype wire
